// ### rtl/periph_irq_enable_bank.sv
/*
 * Peripheral interrupt enable bank: two 8-bit enable registers, a global
 * peripheral gate and an AXI4-Lite slave to reach them.
 * Assumes request inputs synchronous to i_ref_clk; the global gate bit is
 * held here as a stand-in for the core control register.
 */
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module periph_irq_enable_bank
    import irq_enable_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // AXI4-Lite write address
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    // AXI4-Lite write data
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    // AXI4-Lite write response
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic      [1:0]  o_bresp,
    // AXI4-Lite read address
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    // AXI4-Lite read data
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic      [31:0] o_rdata,
    output logic      [1:0]  o_rresp,
    // Peripheral requests
    input  wire logic        i_osc_fail_req,
    input  wire logic        i_clock_switch_done_req,
    input  wire logic        i_logic_cell_a_req,
    input  wire logic        i_logic_cell_b_req,
    input  wire logic        i_waveform_gen_req,
    input  wire logic        i_capcomp_a_req,
    input  wire logic        i_capcomp_b_req,
    // Gated requests to the core
    output logic      [6:0]  o_gated_req,
    output logic             o_periph_irq
);

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_TWO    = 3'b001,
        SEL_THREE  = 3'b010,
        SEL_GATE   = 3'b011,
        SEL_STATUS = 3'b100
    } reg_sel_t;

    // Shared by the write and read paths so both agree on the map
    function automatic reg_sel_t decode_addr(input logic [7:0] addr);
        case (addr)
            OFF_ENABLE_TWO:   decode_addr = SEL_TWO;
            OFF_ENABLE_THREE: decode_addr = SEL_THREE;
            OFF_GLOBAL_GATE:  decode_addr = SEL_GATE;
            OFF_REQ_STATUS:   decode_addr = SEL_STATUS;
            default:          decode_addr = SEL_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;

    assign o_awready = !aw_held_reg && !bvalid_reg;
    assign o_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (i_awvalid && o_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (decode_addr(addr) != SEL_NONE);
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && i_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_reg;
    assign o_bresp  = bresp_reg;

    // Only byte lane 0 carries register data
    logic wr_lane0;
    logic wr_two;
    logic wr_three;
    logic wr_gate;

    assign wr_lane0 = wr_fire && w_strb_reg[0];
    assign wr_two   = wr_lane0 && (decode_addr(aw_addr_reg) == SEL_TWO);
    assign wr_three = wr_lane0 && (decode_addr(aw_addr_reg) == SEL_THREE);
    assign wr_gate  = wr_lane0 && (decode_addr(aw_addr_reg) == SEL_GATE);

    // ------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------
    logic [7:0] enable_two;
    logic [7:0] enable_three;
    logic       global_gate_reg;

    enable_reg8 #(
        .MASK      (MASK_ENABLE_TWO),
        .RST_VALUE (RST_ENABLE_TWO)
    ) u_enable_two (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (wr_two),
        .i_wr_data (w_data_reg[7:0]),
        .o_value   (enable_two)
    );

    enable_reg8 #(
        .MASK      (MASK_ENABLE_THREE),
        .RST_VALUE (RST_ENABLE_THREE)
    ) u_enable_three (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (wr_three),
        .i_wr_data (w_data_reg[7:0]),
        .o_value   (enable_three)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            global_gate_reg <= RST_GLOBAL_GATE;
        end else if (wr_gate) begin
            global_gate_reg <= w_data_reg[BIT_GLOBAL_GATE];
        end
    end

    // ------------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------------
    logic [NUM_REQ-1:0] req_vec;
    logic [NUM_REQ-1:0] en_vec;
    logic [NUM_REQ-1:0] gated;
    logic               any_gated;

    assign req_vec = {i_capcomp_b_req, i_capcomp_a_req, i_waveform_gen_req,
                      i_logic_cell_b_req, i_logic_cell_a_req,
                      i_clock_switch_done_req, i_osc_fail_req};

    assign en_vec[0] = enable_two[BIT_OSC_FAIL];
    assign en_vec[1] = enable_two[BIT_CLK_SWITCH];
    assign en_vec[2] = enable_two[BIT_LOGIC_CELL_A];
    assign en_vec[3] = enable_two[BIT_LOGIC_CELL_B];
    assign en_vec[4] = enable_three[BIT_WAVEFORM_GEN];
    assign en_vec[5] = enable_three[BIT_CAPCOMP_A];
    assign en_vec[6] = enable_three[BIT_CAPCOMP_B];

    irq_gate u_gate (
        .i_req         (req_vec),
        .i_enable      (en_vec),
        .i_global_gate (global_gate_reg),
        .o_gated       (gated),
        .o_any         (any_gated)
    );

    // Registered so the outputs come from flip-flops
    logic [6:0] gated_reg;
    logic       periph_irq_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gated_reg      <= 7'h00;
            periph_irq_reg <= 1'b0;
        end else begin
            gated_reg      <= gated;
            periph_irq_reg <= any_gated;
        end
    end

    assign o_gated_req  = gated_reg;
    assign o_periph_irq = periph_irq_reg;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    assign o_arready = !rvalid_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            case (decode_addr(i_araddr))
                SEL_TWO:    rdata_reg <= {24'h00_0000, enable_two};
                SEL_THREE:  rdata_reg <= {24'h00_0000, enable_three};
                SEL_GATE:   rdata_reg <= {31'h0, global_gate_reg};
                SEL_STATUS: rdata_reg <= {25'h0, gated_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && i_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_reg;
    assign o_rdata  = rdata_reg;
    assign o_rresp  = rresp_reg;

endmodule // periph_irq_enable_bank

`default_nettype wire

// ### rtl/irq_enable_pkg.sv
/*
 * Package for the peripheral interrupt enable bank: register byte offsets,
 * field positions, write masks and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package irq_enable_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE_TWO   = 8'h00;
    localparam logic [7:0] OFF_ENABLE_THREE = 8'h04;
    localparam logic [7:0] OFF_GLOBAL_GATE  = 8'h08;
    localparam logic [7:0] OFF_REQ_STATUS   = 8'h0c;

    // Field positions, second enable register
    localparam int BIT_OSC_FAIL     = 7;
    localparam int BIT_CLK_SWITCH   = 6;
    localparam int BIT_LOGIC_CELL_B = 1;
    localparam int BIT_LOGIC_CELL_A = 0;

    // Field positions, third enable register
    localparam int BIT_WAVEFORM_GEN = 6;
    localparam int BIT_CAPCOMP_B    = 1;
    localparam int BIT_CAPCOMP_A    = 0;

    // Field position of the global gate in its register
    localparam int BIT_GLOBAL_GATE  = 0;

    // Implemented bits; all others read zero and ignore writes
    localparam logic [7:0] MASK_ENABLE_TWO   = 8'hc3;
    localparam logic [7:0] MASK_ENABLE_THREE = 8'h43;

    // Values after any reset
    localparam logic [7:0] RST_ENABLE_TWO    = 8'h00;
    localparam logic [7:0] RST_ENABLE_THREE  = 8'h00;
    localparam logic       RST_GLOBAL_GATE   = 1'b0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Number of peripheral request lines
    localparam int NUM_REQ = 7;

endpackage

// ### rtl/enable_reg8.sv
/*
 * One 8-bit enable register with a fixed mask of implemented bits.
 * Assumes a one-cycle write strobe in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module enable_reg8 #(
    parameter logic [7:0] MASK      = 8'hff,
    parameter logic [7:0] RST_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Write port
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    // Stored value
    output logic      [7:0] o_value
);

    logic [7:0] value_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            value_reg <= RST_VALUE & MASK;
        end else if (i_wr_en) begin
            value_reg <= i_wr_data & MASK;
        end
    end

    assign o_value = value_reg;

endmodule // enable_reg8

`default_nettype wire

// ### rtl/irq_gate.sv
/*
 * Gating of peripheral requests by individual enables and the global gate.
 * Assumes request inputs are levels synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_gate
    import irq_enable_pkg::*;
(
    // Requests and enables
    input  wire logic [NUM_REQ-1:0] i_req,
    input  wire logic [NUM_REQ-1:0] i_enable,
    input  wire logic               i_global_gate,
    // Gated requests
    output logic      [NUM_REQ-1:0] o_gated,
    output logic                    o_any
);

    assign o_gated = i_global_gate ? (i_req & i_enable) : '0;
    assign o_any   = |o_gated;

endmodule // irq_gate

`default_nettype wire

// ### tb/irq_enable_assertions.sv
/*
 * Checker for the peripheral interrupt enable bank.
 * Assumes it is bound to the bank's top module ports.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_enable_assertions (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Requests and gated outputs
    input  wire logic       i_osc_fail_req,
    input  wire logic       i_clock_switch_done_req,
    input  wire logic       i_logic_cell_a_req,
    input  wire logic       i_logic_cell_b_req,
    input  wire logic       i_waveform_gen_req,
    input  wire logic       i_capcomp_a_req,
    input  wire logic       i_capcomp_b_req,
    input  wire logic [6:0] o_gated_req,
    input  wire logic       o_periph_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    property p_osc; o_gated_req[0] |-> $past(i_osc_fail_req); endproperty
    a_osc: assert property (p_osc) else $error("osc fail gated without request");
    property p_csw; o_gated_req[1] |-> $past(i_clock_switch_done_req); endproperty
    a_csw: assert property (p_csw) else $error("clock switch gated without request");
    property p_cla; o_gated_req[2] |-> $past(i_logic_cell_a_req); endproperty
    a_cla: assert property (p_cla) else $error("cell a gated without request");
    property p_clb; o_gated_req[3] |-> $past(i_logic_cell_b_req); endproperty
    a_clb: assert property (p_clb) else $error("cell b gated without request");
    property p_wav; o_gated_req[4] |-> $past(i_waveform_gen_req); endproperty
    a_wav: assert property (p_wav) else $error("waveform gated without request");
    property p_cca; o_gated_req[5] |-> $past(i_capcomp_a_req); endproperty
    a_cca: assert property (p_cca) else $error("capcomp a gated without request");
    property p_ccb; o_gated_req[6] |-> $past(i_capcomp_b_req); endproperty
    a_ccb: assert property (p_ccb) else $error("capcomp b gated without request");
    property p_any; o_periph_irq == (|o_gated_req); endproperty
    a_any: assert property (p_any) else $error("summary request mismatch");
    property p_rst; $rose(i_rst_n) |-> o_gated_req == 7'h00 && !o_periph_irq; endproperty
    a_rst: assert property (p_rst) else $error("request out of reset");
endmodule // irq_enable_assertions

bind periph_irq_enable_bank irq_enable_assertions u_chk (
    .i_ref_clk               (i_ref_clk),
    .i_rst_n                 (i_rst_n),
    .i_osc_fail_req          (i_osc_fail_req),
    .i_clock_switch_done_req (i_clock_switch_done_req),
    .i_logic_cell_a_req      (i_logic_cell_a_req),
    .i_logic_cell_b_req      (i_logic_cell_b_req),
    .i_waveform_gen_req      (i_waveform_gen_req),
    .i_capcomp_a_req         (i_capcomp_a_req),
    .i_capcomp_b_req         (i_capcomp_b_req),
    .o_gated_req             (o_gated_req),
    .o_periph_irq            (o_periph_irq)
);

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench for the peripheral interrupt enable bank.
 * Assumes the bank's AXI4-Lite map and one-cycle gated request latency.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import irq_enable_pkg::*;
    logic i_ref_clk = 0, i_rst_n = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [6:0] req = 0;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] ob, orr;
    wire [31:0] rdata;
    wire [6:0] gated;
    wire irq;
    int error_cnt = 0, n_tests = 0;

    periph_irq_enable_bank uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(ob),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(orr),
        .i_osc_fail_req(req[0]), .i_clock_switch_done_req(req[1]),
        .i_logic_cell_a_req(req[2]), .i_logic_cell_b_req(req[3]),
        .i_waveform_gen_req(req[4]), .i_capcomp_a_req(req[5]),
        .i_capcomp_b_req(req[6]), .o_gated_req(gated), .o_periph_irq(irq));

    initial forever #12.5 i_ref_clk = ~i_ref_clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        @(posedge i_ref_clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(negedge i_ref_clk);
            ha = awvalid & awready; hw = wvalid & wready; hb = bvalid; bresp = ob;
            @(posedge i_ref_clk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end while (!hb);
        bready <= 0;
    endtask

    task rdr(input logic [7:0] a);
        logic ha, hv;
        @(posedge i_ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(negedge i_ref_clk);
            ha = arvalid & arready; hv = rvalid; rd = rdata; rresp = orr;
            @(posedge i_ref_clk);
            if (ha) arvalid <= 0;
        end while (!hv);
        rready <= 0;
    endtask

    task gchk(input logic [6:0] exp);
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk({irq, gated}, {|exp, exp});
    endtask

    task t_regs;
        rdr(OFF_ENABLE_TWO); chk(rd, 0);
        chk(rresp, RESP_OKAY);
        rdr(OFF_ENABLE_THREE); chk(rd, 0);
        wr(OFF_ENABLE_TWO, 32'hff); rdr(OFF_ENABLE_TWO); chk(rd, 32'hc3);
        chk(bresp, RESP_OKAY);
        wr(OFF_ENABLE_THREE, 32'hff); rdr(OFF_ENABLE_THREE); chk(rd, 32'h43);
        wr(OFF_ENABLE_THREE, 32'hbc); rdr(OFF_ENABLE_THREE); chk(rd, 0);
        // Lane 0 strobe low leaves the register alone
        @(posedge i_ref_clk) wstrb <= 4'he;
        wr(OFF_ENABLE_TWO, 32'h00);
        @(posedge i_ref_clk) wstrb <= 4'hf;
        rdr(OFF_ENABLE_TWO);
        chk(rd, 32'hc3);
        wr(8'h10, 32'hff);
        chk(bresp, RESP_SLVERR);
        rdr(8'h10); chk(rresp, RESP_SLVERR);
        chk(rd, 0);
        $display("test regs done");
    endtask

    task t_gate;
        logic [7:0] v [7] = '{8'h80, 8'h40, 8'h01, 8'h02, 8'h40, 8'h01, 8'h02};
        wr(OFF_ENABLE_TWO, 32'hc3); wr(OFF_ENABLE_THREE, 32'h43);
        @(posedge i_ref_clk) req <= 7'h7f;
        gchk(7'h00);
        wr(OFF_GLOBAL_GATE, 32'h1); gchk(7'h7f);
        rdr(OFF_REQ_STATUS);
        chk(rd, 32'h7f);
        @(posedge i_ref_clk) req <= 7'h55;
        gchk(7'h55);
        for (int i = 0; i < 7; i++) begin
            wr(OFF_ENABLE_TWO, i < 4 ? {24'h0, v[i]} : 32'h0);
            wr(OFF_ENABLE_THREE, i < 4 ? 32'h0 : {24'h0, v[i]});
            req <= 7'h7f; gchk(7'h01 << i);
        end
        $display("test gate done");
    endtask

    task t_rst2;
        wr(OFF_ENABLE_TWO, 32'hc3);
        @(posedge i_ref_clk) i_rst_n <= 0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1;
        rdr(OFF_ENABLE_TWO); chk(rd, 0);
        rdr(OFF_ENABLE_THREE);
        chk(rd, 0);
        rdr(OFF_GLOBAL_GATE);
        chk(rd, 0);
        gchk(7'h00);
        // Gate open again: cleared enables must still block everything
        wr(OFF_GLOBAL_GATE, 32'h1);
        gchk(7'h00);
        $display("test reset done");
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        error_cnt++;
        test_done;
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1;
        t_regs;
        t_gate;
        t_rst2;
        test_done;
    end
endmodule // testbench

`default_nettype wire
